// >>> rtl/speed_step_and_run_select.sv
// Speed reference step selection and run command decoding for the drive.
`timescale 1ns/1ps
`default_nettype none
module speed_step_and_run_select #(
	parameter int MI_COUNT    = 8,                             // Number of multi-function inputs.
	parameter int FW          = 16,                            // Width of a frequency word.
	parameter int HOLD_CYCLES = speed_run_pkg::HOLD_CYCLES     // Run hold qualification count.
) (
	input  wire logic                  ref_clk,
	input  wire logic                  rst_b,
	input  wire logic                  forward_run_input,
	input  wire logic                  reverse_run_input,
	input  wire logic [MI_COUNT-1:0]   multi_input_pin,
	input  wire logic [MI_COUNT*8-1:0] multi_input_function,
	input  wire logic                  init_three_wire,
	input  wire logic [2:0]            freq_source_select,
	input  wire logic [1:0]            run_source_select,
	input  wire logic [7:0]            second_analog_function,
	input  wire logic [7:0]            third_analog_function,
	input  wire logic [FW-1:0]         first_analog_input,
	input  wire logic [FW-1:0]         second_analog_input,
	input  wire logic [FW-1:0]         third_analog_input,
	input  wire logic [8*FW-1:0]       preset_freq,
	input  wire logic [FW-1:0]         jog_preset_freq,
	input  wire logic                  key_run,
	input  wire logic                  key_stop,
	input  wire logic                  key_jog,
	input  wire logic                  key_reverse,
	output logic [FW-1:0]              freq_reference,
	output logic [3:0]                 step_index,
	output logic                       jog_active,
	output logic                       run_forward,
	output logic                       run_reverse,
	output logic                       three_wire_mode
);

	// Refuse settings the logic cannot serve; the drive has at most ten multi-function inputs.
	if (MI_COUNT < 1 || MI_COUNT > 10 || FW < 1 || HOLD_CYCLES < 1) begin : g_bad_param
		$error("speed_step_and_run_select: bad parameter");
	end

	// Two-flop synchronisers for every contact pin; stage one is read only by stage two.
	localparam int NPIN = MI_COUNT + 2;
	logic [NPIN-1:0] sync1_reg, sync1_next;
	logic [NPIN-1:0] sync2_reg, sync2_next;

	always_comb begin
		sync1_next = {multi_input_pin, reverse_run_input, forward_run_input};
		sync2_next = sync1_reg;
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= sync1_next;
			sync2_reg <= sync2_next;
		end
	end

	// Clean levels after synchronisation.
	logic                fwd_in;
	logic                rev_in;
	logic [MI_COUNT-1:0] mi_in;
	assign fwd_in = sync2_reg[0];
	assign rev_in = sync2_reg[1];
	assign mi_in  = sync2_reg[NPIN-1:2];

	// Decode function codes per input; an input with a code contributes its level.
	logic [MI_COUNT-1:0] is_s0, is_s1, is_s2, is_jog, is_dir;
	genvar gi;
	generate
		for (gi = 0; gi < MI_COUNT; gi++) begin : g_decode
			logic [7:0] fn;
			assign fn         = multi_input_function[gi*8 +: 8];
			assign is_s0[gi]  = (fn == speed_run_pkg::FN_STEP0);
			assign is_s1[gi]  = (fn == speed_run_pkg::FN_STEP1);
			assign is_s2[gi]  = (fn == speed_run_pkg::FN_STEP2);
			assign is_jog[gi] = (fn == speed_run_pkg::FN_JOG);
			// Three-wire init forces input 3 to carry direction.
			assign is_dir[gi] = (fn == speed_run_pkg::FN_THREE_WIRE) ||
				(init_three_wire && gi == speed_run_pkg::DIR_INIT_INDEX);
		end
	endgenerate

	// Step bits and jog are the OR of all inputs that hold that function.
	logic [2:0] step_bits;
	logic       jog_sel;
	logic       dir_sel;
	logic       three_wire;
	assign step_bits  = {|(is_s2 & mi_in), |(is_s1 & mi_in), |(is_s0 & mi_in)};
	assign jog_sel    = |(is_jog & mi_in);
	assign dir_sel    = |(is_dir & mi_in);
	assign three_wire = |is_dir;

	// Reference selection; jog wins over every step.
	logic [FW-1:0] freq_next;
	logic [3:0]    step_next;
	always_comb begin
		freq_next = '0;
		step_next = {1'b0, step_bits} + 4'h1;
		if (jog_sel) begin
			freq_next = jog_preset_freq;
			step_next = 4'h9;
		end else begin
			unique case (step_bits)
				3'h0: freq_next = (freq_source_select == speed_run_pkg::FSRC_TERMINALS) ?
					first_analog_input : preset_freq[0 +: FW];
				3'h1: freq_next = (second_analog_function == speed_run_pkg::AN_AUX1) ?
					second_analog_input : preset_freq[FW +: FW];
				3'h2: freq_next = (third_analog_function == speed_run_pkg::AN_AUX2) ?
					third_analog_input : preset_freq[2*FW +: FW];
				default: freq_next = preset_freq[step_bits*FW +: FW];
			endcase
		end
	end

	// Run decode per source; serial and option sources are handled elsewhere and give no run here.
	localparam int HCW = $clog2(HOLD_CYCLES + 1);
	logic [HCW-1:0] hold_cnt_reg, hold_cnt_next;
	logic           latch_reg, latch_next;
	logic           key_run_reg, key_run_next;
	logic           key_rev_reg, key_rev_next;
	logic           fwd_next, rev_next;

	always_comb begin
		hold_cnt_next = '0;
		latch_next    = latch_reg;
		key_run_next  = key_run_reg;
		key_rev_next  = key_rev_reg;
		fwd_next      = 1'b0;
		rev_next      = 1'b0;
		unique case (run_source_select)
			speed_run_pkg::RSRC_OPERATOR: begin
				// Keypad only; stop wins over run if both pressed.
				latch_next = 1'b0;
				if (key_stop)
					key_run_next = 1'b0;
				else if (key_run || key_jog)
					key_run_next = 1'b1;
				key_rev_next = key_reverse;
				fwd_next = key_run_next && !key_rev_next;
				rev_next = key_run_next && key_rev_next;
			end
			speed_run_pkg::RSRC_TERMINAL: begin
				key_run_next = 1'b0;
				if (three_wire) begin
					// Run input must be seen for the full hold time before it latches.
					if (fwd_in && hold_cnt_reg < HCW'(HOLD_CYCLES))
						hold_cnt_next = hold_cnt_reg + 1'b1;
					else if (fwd_in)
						hold_cnt_next = hold_cnt_reg;
					if (!rev_in)
						latch_next = 1'b0;
					else if (hold_cnt_next == HCW'(HOLD_CYCLES))
						latch_next = 1'b1;
					fwd_next = latch_next && !dir_sel;
					rev_next = latch_next && dir_sel;
				end else begin
					latch_next = 1'b0;
					// Both on together is contradictory, so neither runs.
					fwd_next = fwd_in && !rev_in;
					rev_next = rev_in && !fwd_in;
				end
			end
			default: begin
				latch_next   = 1'b0;
				key_run_next = 1'b0;
			end
		endcase
	end

	// Registered outputs.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			hold_cnt_reg    <= '0;
			latch_reg       <= 1'b0;
			key_run_reg     <= 1'b0;
			key_rev_reg     <= 1'b0;
			freq_reference  <= '0;
			step_index      <= 4'h1;
			jog_active      <= 1'b0;
			run_forward     <= 1'b0;
			run_reverse     <= 1'b0;
			three_wire_mode <= 1'b0;
		end else begin
			hold_cnt_reg    <= hold_cnt_next;
			latch_reg       <= latch_next;
			key_run_reg     <= key_run_next;
			key_rev_reg     <= key_rev_next;
			freq_reference  <= freq_next;
			step_index      <= step_next;
			jog_active      <= jog_sel;
			run_forward     <= fwd_next;
			run_reverse     <= rev_next;
			three_wire_mode <= three_wire;
		end
	end

	// Jog wins: one cycle later the step index is 9 and the reference is the jog preset.
	AST_JOG_PRIORITY: assert property (@(posedge ref_clk) disable iff (!rst_b)
		jog_sel |=> (step_index == 4'h9 && freq_reference == $past(jog_preset_freq)))
		else $error("jog not given priority");
	AST_STEP_NUMBER: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!jog_sel |=> step_index == {1'b0, $past(step_bits)} + 4'h1)
		else $error("step index wrong");
	AST_STEP1_SRC: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(!jog_sel && step_bits == 3'h0 && freq_source_select == 3'h1)
		|=> freq_reference == $past(first_analog_input))
		else $error("step 1 source wrong");
	AST_STEP2_SRC: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(!jog_sel && step_bits == 3'h1 && second_analog_function == 8'h1F)
		|=> freq_reference == $past(preset_freq[FW +: FW]))
		else $error("step 2 source wrong");
	AST_STEP3_SRC: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(!jog_sel && step_bits == 3'h2 && third_analog_function == 8'h03)
		|=> freq_reference == $past(third_analog_input))
		else $error("step 3 source wrong");
	AST_NO_RUN_OTHER: assert property (@(posedge ref_clk) disable iff (!rst_b)
		run_source_select[1] |=> !run_forward && !run_reverse)
		else $error("run from serial or option source");
	AST_KEY_STOP: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(run_source_select == 2'h0 && key_stop) |=> !run_forward && !run_reverse)
		else $error("keypad stop ignored");
	AST_TWO_WIRE_FWD: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(run_source_select == 2'h1 && !three_wire && fwd_in && !rev_in) |=> run_forward)
		else $error("two-wire forward missing");
	AST_TWO_WIRE_REV: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(run_source_select == 2'h1 && !three_wire && !rev_in) |=> !run_reverse)
		else $error("two-wire reverse not stopped");
	AST_THREE_WIRE: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(init_three_wire || multi_input_function[7:0] == 8'h00) |=> three_wire_mode)
		else $error("three-wire not selected");
	AST_STOP_CLEARS: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(run_source_select == 2'h1 && three_wire && !rev_in) |=> !latch_reg && !run_forward)
		else $error("stop did not clear latch");
	AST_SHORT_PULSE: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(HOLD_CYCLES > 1 && three_wire && $rose(fwd_in) && !latch_reg) |=> !latch_reg)
		else $error("latched before hold time");

	COV_JOG:   cover property (@(posedge ref_clk) disable iff (!rst_b) jog_active);
	COV_STEP8: cover property (@(posedge ref_clk) disable iff (!rst_b) step_index == 4'h8);
	COV_LATCH: cover property (@(posedge ref_clk) disable iff (!rst_b)
		latch_reg && !fwd_in && run_reverse);

endmodule : speed_step_and_run_select
`default_nettype wire

// >>> rtl/speed_run_pkg.sv
// Constants for the speed step and run command selection block.
package speed_run_pkg;

	// Multi-function input function codes.
	localparam logic [7:0] FN_THREE_WIRE = 8'h00;
	localparam logic [7:0] FN_STEP0      = 8'h03;
	localparam logic [7:0] FN_STEP1      = 8'h04;
	localparam logic [7:0] FN_STEP2      = 8'h05;
	localparam logic [7:0] FN_JOG        = 8'h06;

	// Analog function codes.
	localparam logic [7:0] AN_AUX1   = 8'h02;
	localparam logic [7:0] AN_AUX2   = 8'h03;
	localparam logic [7:0] AN_UNUSED = 8'h1F;

	// Frequency source values.
	localparam logic [2:0] FSRC_OPERATOR  = 3'h0;
	localparam logic [2:0] FSRC_TERMINALS = 3'h1;

	// Run source values and reset default.
	localparam logic [1:0] RSRC_OPERATOR = 2'h0;
	localparam logic [1:0] RSRC_TERMINAL = 2'h1;
	localparam logic [1:0] RSRC_SERIAL   = 2'h2;
	localparam logic [1:0] RSRC_OPTION   = 2'h3;
	localparam logic [1:0] RSRC_RESET    = 2'h1;

	// Multi-function input index used for direction after three-wire init (input 3 = index 0).
	localparam int DIR_INIT_INDEX = 0;

	// Least run hold time and clock rate.
	localparam int HOLD_MS      = 50;
	localparam int CLK_HZ       = 40_000_000;
	localparam int HOLD_CYCLES  = (HOLD_MS * (CLK_HZ / 1000));

endpackage : speed_run_pkg

// >>> sim/contact_switches.sv
// External contact model driving the run and multi-function terminals.
`timescale 1ns/1ps
`default_nettype none
module contact_switches #(
	parameter int N = 8 // Number of multi-function contacts.
) (
	input  wire logic         ref_clk,
	output logic              forward_run_input,
	output logic              reverse_run_input,
	output logic [N-1:0]      multi_input_pin
);
	// All contacts are open at power-up.
	initial begin
		forward_run_input = 1'b0;
		reverse_run_input = 1'b0;
		multi_input_pin = '0;
	end
	// Moves every contact together just after a clock edge.
	task automatic set(input logic f, input logic r, input logic [N-1:0] p);
		@(posedge ref_clk);
		forward_run_input <= f;
		reverse_run_input <= r;
		multi_input_pin <= p;
	endtask
	// A run push held for n cycles; short pushes must not latch.
	task automatic push(input int n);
		@(posedge ref_clk);
		forward_run_input <= 1'b1;
		repeat (n) @(posedge ref_clk);
		forward_run_input <= 1'b0;
	endtask
endmodule // contact_switches
`default_nettype wire

// >>> sim/speed_step_and_run_select_tb.sv
// Self-checking bench for step selection and run decoding.
`timescale 1ns/1ps
`default_nettype none
module speed_step_and_run_select_tb;
	logic         ref_clk = 1'b0, rst_b = 1'b0, f_in, r_in, i3w = 1'b0;
	logic         k_run = 1'b0, k_stop = 1'b0, k_jog = 1'b0, k_rev = 1'b0;
	logic [7:0]   pins, fn2 = 8'h1F, fn3 = 8'h1F;
	logic [63:0]  mfn = 64'h0F0F0F0F_06050403; // Pins 0..3 hold step and jog roles.
	logic [2:0]   fsrc = 3'h0;
	logic [1:0]   rsrc = 2'h1;
	logic [15:0]  ain1 = 16'h0, ain2 = 16'h0, ain3 = 16'h0, jog = 16'h0, fref, ef;
	logic [127:0] pre = '0;
	logic [3:0]   sidx;
	logic         jact, rfw, rrv, tw;
	logic [31:0]  v;
	int           n_mismatch = 0, total_checks = 0, seed = 52, k, n;
	// Free-running 40 MHz clock.
	always #12.5 ref_clk = ~ref_clk;
	contact_switches #(.N(8)) i_sw (.ref_clk(ref_clk), .forward_run_input(f_in),
		.reverse_run_input(r_in), .multi_input_pin(pins));
	speed_step_and_run_select #(.HOLD_CYCLES(8)) i_dut (.ref_clk(ref_clk), .rst_b(rst_b),
		.forward_run_input(f_in), .reverse_run_input(r_in), .multi_input_pin(pins),
		.multi_input_function(mfn), .init_three_wire(i3w), .freq_source_select(fsrc),
		.run_source_select(rsrc), .second_analog_function(fn2),
		.third_analog_function(fn3), .first_analog_input(ain1), .second_analog_input(ain2),
		.third_analog_input(ain3), .preset_freq(pre), .jog_preset_freq(jog),
		.key_run(k_run), .key_stop(k_stop), .key_jog(k_jog), .key_reverse(k_rev),
		.freq_reference(fref), .step_index(sidx), .jog_active(jact),
		.run_forward(rfw), .run_reverse(rrv), .three_wire_mode(tw));
	// Counts every comparison and reports a mismatch at once.
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Pins need three edges to show, so results are read mid-cycle after that.
	task automatic settle(input int c);
		repeat (c) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask
	// One keypad press: run, stop and jog are pulses, reverse is a level.
	task automatic key(input logic r, input logic s, input logic j, input logic d);
		@(posedge ref_clk);
		{k_run, k_stop, k_jog, k_rev} <= {r, s, j, d};
		@(posedge ref_clk);
		{k_run, k_stop, k_jog} <= 3'h0;
		settle(2);
	endtask
	task automatic report_and_stop();
		$display("Checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// A hang is cut short well past the expected few hundred cycles.
	initial begin
		#200_000;
		n_mismatch++;
		report_and_stop();
	end
	// Main sequence.
	initial begin
		settle(5);
		check("reset freq", fref, 16'h0000);
		check("reset step", 16'(sidx), 16'h0001);
		@(posedge ref_clk);
		rst_b <= 1'b1;
		// Random steps, jog, sources and two-wire contacts against the model.
		for (k = 0; k < 32; k++) begin
			v = $random(seed);
			@(posedge ref_clk);
			fsrc <= {2'h0, v[4]};
			fn2 <= v[5] ? 8'h02 : 8'h1F;
			fn3 <= v[6] ? 8'h03 : 8'h1F;
			ain1 <= 16'($random(seed));
			ain2 <= 16'($random(seed));
			ain3 <= 16'($random(seed));
			jog <= 16'($random(seed));
			pre <= {$random(seed), $random(seed), $random(seed), $random(seed)};
			i_sw.set(v[0], v[1], {4'h0, v[10:7]});
			settle(4);
			n = pins[2:0] + 1;
			if (pins[3])
				ef = jog;
			else if (n == 1 && fsrc == 3'h1)
				ef = ain1;
			else if (n == 2 && fn2 == 8'h02)
				ef = ain2;
			else if (n == 3 && fn3 == 8'h03)
				ef = ain3;
			else
				ef = pre[(n-1)*16 +: 16];
			check("freq", fref, ef);
			check("step", 16'(sidx), pins[3] ? 16'h0009 : 16'(n));
			check("jog", 16'(jact), 16'(pins[3]));
			check("fwd", 16'(rfw), 16'(v[0] & ~v[1]));
			check("rev", 16'(rrv), 16'(v[1] & ~v[0]));
		end
		// Only the terminal source lets the forward contact run.
		i_sw.set(1'b1, 1'b0, 8'h00);
		for (k = 0; k < 4; k++) begin
			@(posedge ref_clk);
			rsrc <= k[1:0];
			settle(4);
			check("source", 16'(rfw), 16'(k == 1));
		end
		// Keypad run, jog, direction and stop with the contact still closed.
		@(posedge ref_clk);
		rsrc <= 2'h0;
		key(1'b1, 1'b0, 1'b0, 1'b0);
		check("key run", 16'(rfw), 16'h0001);
		key(1'b0, 1'b0, 1'b0, 1'b1);
		check("key rev", 16'({rfw, rrv}), 16'h0001);
		key(1'b0, 1'b1, 1'b0, 1'b0);
		check("key stop", 16'(rrv), 16'h0000);
		key(1'b0, 1'b0, 1'b1, 1'b0);
		check("key jog", 16'(rfw), 16'h0001);
		key(1'b0, 1'b1, 1'b0, 1'b0);
		// Three-wire by a direction-coded pin, stop contact closed.
		@(posedge ref_clk);
		rsrc <= 2'h1;
		mfn[39:32] <= 8'h00;
		i_sw.set(1'b0, 1'b1, 8'h00);
		settle(4);
		check("3w mode", 16'(tw), 16'h0001);
		i_sw.push(4);
		settle(4);
		check("short push", 16'(rfw), 16'h0000);
		i_sw.push(12);
		settle(4);
		check("latched", 16'(rfw), 16'h0001);
		i_sw.set(1'b0, 1'b1, 8'h10);
		settle(4);
		check("3w rev", 16'({rfw, rrv}), 16'h0001);
		i_sw.set(1'b0, 1'b0, 8'h10);
		settle(4);
		check("stop", 16'({rfw, rrv}), 16'h0000);
		// Three-wire by initialization: the first pin becomes direction.
		@(posedge ref_clk);
		mfn[39:32] <= 8'h0F;
		i3w <= 1'b1;
		i_sw.set(1'b0, 1'b1, 8'h00);
		i_sw.push(12);
		i_sw.set(1'b0, 1'b1, 8'h01);
		settle(4);
		check("init dir", 16'({tw, rfw, rrv}), 16'h0005);
		report_and_stop();
	end
endmodule // speed_step_and_run_select_tb
`default_nettype wire
